/* logic/iqgor_pkg.sv */
// constants and register map for the iq gain, offset and ramp stage
// What this block does
// [RQ1] 13-bit signed phase skew from upper five and lower eight bits, applied I into Q
// [RQ2] four lane sleep bits each force one of data bits 3..0 to zero
// [RQ3] 16-bit I offset from two bytes added to every I sample
// [RQ4] separate 16-bit Q offset from its own two bytes added to every Q sample
// [RQ5] I samples multiplied by 6-bit gain, lsb one thirty-second, reset 0x20 unity
// [RQ6] Q samples multiplied by independent 6-bit gain, same weighting, reset unity
// [RQ7] turn-on raises gain by rise step every four clocks up to I gain
// [RQ8] turn-off lowers gain by fall step every four clocks down to zero
// [RQ9] software keeps both step values no larger than the I gain setting
// [RQ10] manual off bit 7 turns output off via ramp, clearing turns it on
// [RQ11] read-only status bit 6 is one while output off, also after reset
// [RQ12] software enables the digital gain function before using manual off
// [RQ13] status follows on/off state only while gain function is enabled
// [RQ14] with gate stepping enabled, transmit gate edges ramp output on or off
// [RQ15] ramp clamps at target or zero instead of overshooting
package iqgor_pkg;
  // register offsets
  localparam logic [7:0] ADDR_PHASE_LOW = 8'h37;
  localparam logic [7:0] ADDR_PHASE_HIGH = 8'h38;
  localparam logic [7:0] ADDR_LANE_PD = 8'h39;
  localparam logic [7:0] ADDR_I_OFF_LOW = 8'h3b;
  localparam logic [7:0] ADDR_I_OFF_HIGH = 8'h3c;
  localparam logic [7:0] ADDR_Q_OFF_LOW = 8'h3d;
  localparam logic [7:0] ADDR_Q_OFF_HIGH = 8'h3e;
  localparam logic [7:0] ADDR_I_GAIN = 8'h3f;
  localparam logic [7:0] ADDR_Q_GAIN = 8'h40;
  localparam logic [7:0] ADDR_RISE_STEP = 8'h41;
  localparam logic [7:0] ADDR_FALL_STEP = 8'h42;
  // reset values
  localparam logic [5:0] GAIN_RESET = 6'h20;
  localparam logic [5:0] STEP_RESET = 6'h01;
  localparam logic STATUS_RESET = 1'b1;
  // field positions in the fall step register
  localparam int MUTE_BIT = 7;
  localparam int STATUS_BIT = 6;
  // field widths
  localparam int SAMPLE_W = 16;
  localparam int PHASE_HI_W = 5;
  localparam int LANE_W = 4;
  localparam int GAIN_W = 6;
  localparam int RAMP_W = 7;
  // datapath scaling
  localparam int GAIN_SHIFT = 5;
  localparam int PHASE_SHIFT = 14;
  // ramp update cadence, one step every four clocks
  localparam logic [1:0] TICK_LAST = 2'h3;
  localparam logic [15:0] SAT_MAX = 16'h7fff;
  localparam logic [15:0] SAT_MIN = 16'h8000;
endpackage

/* logic/iqgor_top.sv */
// iq phase skew, gain, dc offset and gain ramp stage
`timescale 1ns/1ps
module iqgor_top (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // configuration port
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  // control inputs from elsewhere in the device
  input wire logic iq_gain_func_en_i,
  input wire logic gate_step_en_i,
  input wire logic transmit_gate_i,
  // sample input
  input wire logic sample_valid_i,
  input wire logic [15:0] i_sample_i,
  input wire logic [15:0] q_sample_i,
  // sample output
  output logic out_valid_o,
  output logic [15:0] i_out_o,
  output logic [15:0] q_out_o,
  output logic output_off_o
);

  typedef struct packed {
    logic [7:0] phase_low;
    logic [4:0] phase_high;
    logic [3:0] lane_pd;
    logic [7:0] i_off_low;
    logic [7:0] i_off_high;
    logic [7:0] q_off_low;
    logic [7:0] q_off_high;
    logic [5:0] i_gain;
    logic [5:0] q_gain;
    logic [5:0] rise_step;
    logic [5:0] fall_step;
    logic mute;
    logic status;
    logic [6:0] ramp;
    logic [1:0] tick;
    logic s1_v;
    logic [15:0] s1_i;
    logic [15:0] s1_q;
    logic s2_v;
    logic [15:0] s2_i;
    logic [15:0] s2_q;
    logic out_v;
    logic [15:0] out_i;
    logic [15:0] out_q;
    logic [7:0] rdata;
  } iqgor_state_s;

  localparam iqgor_state_s STATE_RESET = '{
    phase_low: 8'h00,
    phase_high: 5'h00,
    lane_pd: 4'h0,
    i_off_low: 8'h00,
    i_off_high: 8'h00,
    q_off_low: 8'h00,
    q_off_high: 8'h00,
    i_gain: iqgor_pkg::GAIN_RESET,
    q_gain: iqgor_pkg::GAIN_RESET,
    rise_step: iqgor_pkg::STEP_RESET,
    fall_step: iqgor_pkg::STEP_RESET,
    mute: 1'b0,
    status: iqgor_pkg::STATUS_RESET,
    ramp: 7'h00,
    tick: 2'h0,
    s1_v: 1'b0,
    s1_i: 16'h0000,
    s1_q: 16'h0000,
    s2_v: 1'b0,
    s2_i: 16'h0000,
    s2_q: 16'h0000,
    out_v: 1'b0,
    out_i: 16'h0000,
    out_q: 16'h0000,
    rdata: 8'h00
  };

  iqgor_state_s state_reg;
  iqgor_state_s state_next;

  // saturate a wide signed value into a 16-bit sample
  function automatic logic [15:0] iqgor_sat16(input logic signed [31:0] v);
    logic [15:0] r;
    if (v > $signed({16'h0000, iqgor_pkg::SAT_MAX})) begin
      r = iqgor_pkg::SAT_MAX;
    end else if (v < $signed({16'hffff, iqgor_pkg::SAT_MIN})) begin
      r = iqgor_pkg::SAT_MIN;
    end else begin
      r = v[15:0];
    end
    return r;
  endfunction

  // scale a sample by an unsigned gain with five fraction bits
  function automatic logic [15:0] iqgor_scale(input logic [15:0] x, input logic [6:0] g);
    logic signed [31:0] p;
    p = $signed({{16{x[15]}}, x}) * $signed({25'h0, g});
    return iqgor_sat16(p >>> iqgor_pkg::GAIN_SHIFT);
  endfunction

  // add a two-byte offset to a sample, saturating instead of wrapping
  function automatic logic [15:0] iqgor_add_off(input logic [15:0] x, input logic [7:0] hi, input logic [7:0] lo);
    logic signed [31:0] s;
    s = $signed({{16{x[15]}}, x}) + $signed({{16{hi[7]}}, hi, lo});
    return iqgor_sat16(s);
  endfunction

  typedef enum logic [3:0] {
    SEL_NONE,
    SEL_PHASE_LOW,
    SEL_PHASE_HIGH,
    SEL_LANE_PD,
    SEL_I_OFF_LOW,
    SEL_I_OFF_HIGH,
    SEL_Q_OFF_LOW,
    SEL_Q_OFF_HIGH,
    SEL_I_GAIN,
    SEL_Q_GAIN,
    SEL_RISE_STEP,
    SEL_FALL_STEP
  } iqgor_sel_e;
  // one address decode shared by writes and reads, so the two maps cannot drift apart
  function automatic iqgor_sel_e iqgor_decode(input logic [7:0] a);
    iqgor_sel_e s;
    if (a == iqgor_pkg::ADDR_PHASE_LOW) begin
      s = SEL_PHASE_LOW;
    end else if (a == iqgor_pkg::ADDR_PHASE_HIGH) begin
      s = SEL_PHASE_HIGH;
    end else if (a == iqgor_pkg::ADDR_LANE_PD) begin
      s = SEL_LANE_PD;
    end else if (a == iqgor_pkg::ADDR_I_OFF_LOW) begin
      s = SEL_I_OFF_LOW;
    end else if (a == iqgor_pkg::ADDR_I_OFF_HIGH) begin
      s = SEL_I_OFF_HIGH;
    end else if (a == iqgor_pkg::ADDR_Q_OFF_LOW) begin
      s = SEL_Q_OFF_LOW;
    end else if (a == iqgor_pkg::ADDR_Q_OFF_HIGH) begin
      s = SEL_Q_OFF_HIGH;
    end else if (a == iqgor_pkg::ADDR_I_GAIN) begin
      s = SEL_I_GAIN;
    end else if (a == iqgor_pkg::ADDR_Q_GAIN) begin
      s = SEL_Q_GAIN;
    end else if (a == iqgor_pkg::ADDR_RISE_STEP) begin
      s = SEL_RISE_STEP;
    end else if (a == iqgor_pkg::ADDR_FALL_STEP) begin
      s = SEL_FALL_STEP;
    end else begin
      s = SEL_NONE;
    end
    return s;
  endfunction

  logic off_req;
  logic [6:0] target;
  logic [7:0] up_step;
  logic [7:0] down_step;
  logic [7:0] up_sum;
  logic [7:0] gap;
  logic on_settled;
  logic [6:0] i_mult;
  logic [6:0] q_mult;
  logic [15:0] i_masked;
  logic [15:0] q_masked;
  logic [12:0] skew;
  logic signed [31:0] skew_prod;
  logic signed [31:0] q_skewed;
  logic [15:0] lane_keep;
  iqgor_sel_e sel;

  always_comb begin
    state_next = state_reg;
    off_req = 1'b0;
    target = 7'h00;
    up_step = 8'h00;
    down_step = 8'h00;
    up_sum = 8'h00;
    gap = 8'h00;
    on_settled = 1'b0;
    i_mult = 7'h00;
    q_mult = 7'h00;
    i_masked = 16'h0000;
    q_masked = 16'h0000;
    skew = 13'h0;
    skew_prod = 32'sh0;
    q_skewed = 32'sh0;
    lane_keep = 16'hffff;

    // configuration writes; status bit is not writable
    sel = iqgor_decode(cfg_addr_i);
    if (cfg_wr_i) begin
      case (sel)
        SEL_PHASE_LOW: begin
          state_next.phase_low = cfg_wdata_i;
        end
        SEL_PHASE_HIGH: begin
          state_next.phase_high = cfg_wdata_i[iqgor_pkg::PHASE_HI_W-1:0];
        end
        SEL_LANE_PD: begin
          state_next.lane_pd = cfg_wdata_i[iqgor_pkg::LANE_W-1:0];
        end
        SEL_I_OFF_LOW: begin
          state_next.i_off_low = cfg_wdata_i;
        end
        SEL_I_OFF_HIGH: begin
          state_next.i_off_high = cfg_wdata_i;
        end
        SEL_Q_OFF_LOW: begin
          state_next.q_off_low = cfg_wdata_i;
        end
        SEL_Q_OFF_HIGH: begin
          state_next.q_off_high = cfg_wdata_i;
        end
        SEL_I_GAIN: begin
          state_next.i_gain = cfg_wdata_i[iqgor_pkg::GAIN_W-1:0];
        end
        SEL_Q_GAIN: begin
          state_next.q_gain = cfg_wdata_i[iqgor_pkg::GAIN_W-1:0];
        end
        SEL_RISE_STEP: begin
          state_next.rise_step = cfg_wdata_i[iqgor_pkg::GAIN_W-1:0];
        end
        SEL_FALL_STEP: begin
          state_next.mute = cfg_wdata_i[iqgor_pkg::MUTE_BIT];
          state_next.fall_step = cfg_wdata_i[iqgor_pkg::GAIN_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // configuration reads, answered one clock later; unmapped reads give zero
    state_next.rdata = 8'h00;
    if (cfg_rd_i) begin
      case (sel)
        SEL_PHASE_LOW: begin
          state_next.rdata = state_reg.phase_low;
        end
        SEL_PHASE_HIGH: begin
          state_next.rdata = {3'h0, state_reg.phase_high};
        end
        SEL_LANE_PD: begin
          state_next.rdata = {4'h0, state_reg.lane_pd};
        end
        SEL_I_OFF_LOW: begin
          state_next.rdata = state_reg.i_off_low;
        end
        SEL_I_OFF_HIGH: begin
          state_next.rdata = state_reg.i_off_high;
        end
        SEL_Q_OFF_LOW: begin
          state_next.rdata = state_reg.q_off_low;
        end
        SEL_Q_OFF_HIGH: begin
          state_next.rdata = state_reg.q_off_high;
        end
        SEL_I_GAIN: begin
          state_next.rdata = {2'h0, state_reg.i_gain};
        end
        SEL_Q_GAIN: begin
          state_next.rdata = {2'h0, state_reg.q_gain};
        end
        SEL_RISE_STEP: begin
          state_next.rdata = {2'h0, state_reg.rise_step};
        end
        SEL_FALL_STEP: begin
          state_next.rdata = {state_reg.mute, state_reg.status, state_reg.fall_step}; // RQ11
        end
        default: begin
          state_next.rdata = 8'h00;
        end
      endcase
    end

    // off request: manual bit or a low transmit gate when gate stepping is on
    off_req = state_reg.mute | (gate_step_en_i & ~transmit_gate_i); // RQ10 RQ14
    target = off_req ? 7'h00 : {1'b0, state_reg.i_gain};
    // steps carry four fraction bits, gain five, so a step counts double
    up_step = {1'b0, state_reg.rise_step, 1'b0};
    down_step = {1'b0, state_reg.fall_step, 1'b0};
    up_sum = {1'b0, state_reg.ramp} + up_step;

    if (!iq_gain_func_en_i) begin
      // function off: programmed gain applies, manual off is ignored and status is frozen
      state_next.ramp = {1'b0, state_reg.i_gain}; // RQ12
      state_next.tick = 2'h0;
      state_next.status = state_reg.status; // RQ13
    end else begin
      state_next.tick = state_reg.tick + 2'h1;
      if (state_reg.tick == iqgor_pkg::TICK_LAST) begin
        if (state_reg.ramp < target) begin
          // a zero step stalls the ramp; software keeps steps sane
          if (up_sum > {1'b0, target}) begin
            state_next.ramp = target; // RQ15
          end else begin
            state_next.ramp = up_sum[6:0]; // RQ7
          end
        end else if (state_reg.ramp > target) begin
          gap = {1'b0, state_reg.ramp} - {1'b0, target};
          if (gap > down_step) begin
            state_next.ramp = state_reg.ramp - down_step[6:0]; // RQ8
          end else begin
            state_next.ramp = target; // RQ15
          end
        end
      end
      state_next.status = (state_next.ramp == 7'h00); // RQ11 RQ13
    end

    // gain selection: I follows the ramp, Q is capped by the ramp until settled
    on_settled = (state_reg.ramp == {1'b0, state_reg.i_gain}) & ~off_req;
    i_mult = state_reg.ramp; // RQ5
    if (!iq_gain_func_en_i || on_settled) begin
      q_mult = {1'b0, state_reg.q_gain}; // RQ6
    end else if (state_reg.ramp < {1'b0, state_reg.q_gain}) begin
      q_mult = state_reg.ramp;
    end else begin
      q_mult = {1'b0, state_reg.q_gain};
    end

    // stage 1: lane sleep mask and phase skew
    lane_keep = {12'hfff, ~state_reg.lane_pd};
    i_masked = i_sample_i & lane_keep; // RQ2
    q_masked = q_sample_i & lane_keep; // RQ2
    skew = {state_reg.phase_high, state_reg.phase_low};
    // small-angle rotation: q plus i times the skew angle in radians
    skew_prod = $signed({{16{i_masked[15]}}, i_masked}) * $signed({{19{skew[12]}}, skew}); // RQ1
    q_skewed = $signed({{16{q_masked[15]}}, q_masked}) + (skew_prod >>> iqgor_pkg::PHASE_SHIFT); // RQ1
    state_next.s1_v = sample_valid_i;
    if (sample_valid_i) begin
      state_next.s1_i = i_masked;
      state_next.s1_q = iqgor_sat16(q_skewed);
    end

    // stage 2: gain
    state_next.s2_v = state_reg.s1_v;
    if (state_reg.s1_v) begin
      state_next.s2_i = iqgor_scale(state_reg.s1_i, i_mult); // RQ5
      state_next.s2_q = iqgor_scale(state_reg.s1_q, q_mult); // RQ6
    end

    // stage 3: dc offset; offset stays even while muted, as the converter expects
    state_next.out_v = state_reg.s2_v;
    if (state_reg.s2_v) begin
      state_next.out_i = iqgor_add_off(state_reg.s2_i, state_reg.i_off_high, state_reg.i_off_low); // RQ3
      state_next.out_q = iqgor_add_off(state_reg.s2_q, state_reg.q_off_high, state_reg.q_off_low); // RQ4
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cfg_rdata_o = state_reg.rdata;
  assign out_valid_o = state_reg.out_v;
  assign i_out_o = state_reg.out_i;
  assign q_out_o = state_reg.out_q;
  assign output_off_o = state_reg.status;

endmodule // iqgor_top

/* sim/iqgor_checker.sv */
// assertions for the iq gain, offset and ramp stage
`timescale 1ns/1ps
module iqgor_checker (
  // watched ports
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic iq_gain_func_en_i,
  input wire logic gate_step_en_i,
  input wire logic transmit_gate_i,
  input wire logic sample_valid_i,
  input wire logic out_valid_o,
  input wire logic [15:0] i_out_o,
  input wire logic output_off_o
);
  // edges of a standing gate-low off request; slowest ramp down is 32 ticks
  logic [7:0] off_cnt_reg;
  logic [7:0] off_cnt_next;
  always_comb begin
    off_cnt_next = 8'h00;
    if (iq_gain_func_en_i && gate_step_en_i && !transmit_gate_i) begin
      off_cnt_next = (off_cnt_reg == 8'hc8) ? off_cnt_reg : off_cnt_reg + 8'h01;
    end
  end
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      off_cnt_reg <= 8'h00;
    end else begin
      off_cnt_reg <= off_cnt_next;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // function off in the read cycle and the one before it, so a one-cycle lag of the flag cannot fool the compare
  sequence s_rd_status;
    (!iq_gain_func_en_i) [*2] ##0 cfg_rd_i && cfg_addr_i == iqgor_pkg::ADDR_FALL_STEP;
  endsequence
  sequence s_hold3;
    $stable(output_off_o) [*3];
  endsequence
  property p_status_rd;
    s_rd_status |=> cfg_rdata_o[6] == $past(output_off_o);
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status bit differs from flag");
  property p_frozen;
    (!iq_gain_func_en_i) [*2] |=> $stable(output_off_o);
  endproperty
  a_frozen: assert property (p_frozen) else $error("flag moved while function off");
  property p_step_rate;
    $changed(output_off_o) |=> s_hold3;
  endproperty
  a_step_rate: assert property (p_step_rate) else $error("flag changed faster than ramp tick");
  property p_lat;
    sample_valid_i |-> ##3 out_valid_o;
  endproperty
  a_lat: assert property (p_lat) else $error("sample lost in pipeline");
  property p_no_out;
    !sample_valid_i |-> ##3 !out_valid_o;
  endproperty
  a_no_out: assert property (p_no_out) else $error("output without sample");
  property p_hold;
    !out_valid_o |-> $stable(i_out_o);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved while not valid");
  property p_lane_rd;
    cfg_rd_i && cfg_addr_i == iqgor_pkg::ADDR_LANE_PD |=> cfg_rdata_o[7:4] == 4'h0;
  endproperty
  a_lane_rd: assert property (p_lane_rd) else $error("unused lane bits read nonzero");
  property p_gate_off;
    off_cnt_reg == 8'h8c |-> output_off_o;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gate low but output still on");
endmodule // iqgor_checker

bind iqgor_top iqgor_checker u_chk (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cfg_rd_i(cfg_rd_i),
  .cfg_addr_i(cfg_addr_i), .cfg_rdata_o(cfg_rdata_o), .iq_gain_func_en_i(iq_gain_func_en_i),
  .gate_step_en_i(gate_step_en_i), .transmit_gate_i(transmit_gate_i), .sample_valid_i(sample_valid_i),
  .out_valid_o(out_valid_o), .i_out_o(i_out_o), .output_off_o(output_off_o));

/* sim/iqgor_src.sv */
// upstream sample source model
`timescale 1ns/1ps
module iqgor_src (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // request from the bench
  input wire logic send_i,
  input wire logic [15:0] i_word_i,
  input wire logic [15:0] q_word_i,
  // stream toward the block
  output logic valid_o,
  output logic [15:0] i_o,
  output logic [15:0] q_o
);
  // idle words invert every cycle so stale data never passes for a sample
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      valid_o <= 1'b0;
      i_o <= 16'h0000;
      q_o <= 16'h0000;
    end else begin
      valid_o <= send_i;
      i_o <= send_i ? i_word_i : ~i_o;
      q_o <= send_i ? q_word_i : ~q_o;
    end
  end
endmodule // iqgor_src

/* sim/testbench.sv */
// self-checking bench for the iq gain, offset and ramp stage
`timescale 1ns/1ps
module testbench;
  logic ref_clk_i, arst_n_i, cfg_wr_i, cfg_rd_i, iq_gain_func_en_i, gate_step_en_i, transmit_gate_i;
  logic sample_valid_i, out_valid_o, output_off_o, send;
  logic [7:0] cfg_addr_i, cfg_wdata_i, cfg_rdata_o;
  logic [15:0] i_sample_i, q_sample_i, i_out_o, q_out_o, i_word, q_word;
  int n_fail;
  int cmp_count;
  iqgor_top dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
    .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
    .iq_gain_func_en_i(iq_gain_func_en_i), .gate_step_en_i(gate_step_en_i), .transmit_gate_i(transmit_gate_i),
    .sample_valid_i(sample_valid_i), .i_sample_i(i_sample_i), .q_sample_i(q_sample_i),
    .out_valid_o(out_valid_o), .i_out_o(i_out_o), .q_out_o(q_out_o), .output_off_o(output_off_o));
  iqgor_src src (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .send_i(send), .i_word_i(i_word),
    .q_word_i(q_word), .valid_o(sample_valid_i), .i_o(i_sample_i), .q_o(q_sample_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    cfg_wr_i <= 1'b1;
    cfg_addr_i <= a;
    cfg_wdata_i <= d;
    @(posedge ref_clk_i);
    cfg_wr_i <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    cfg_rd_i <= 1'b1;
    cfg_addr_i <= a;
    @(posedge ref_clk_i);
    cfg_rd_i <= 1'b0;
    #1;
    chk({8'h00, cfg_rdata_o}, {8'h00, e});
  endtask
  task automatic smp(input logic [15:0] i, input logic [15:0] q, input logic [15:0] ei, input logic [15:0] eq);
    int k;
    @(posedge ref_clk_i);
    send <= 1'b1;
    i_word <= i;
    q_word <= q;
    @(posedge ref_clk_i);
    send <= 1'b0;
    for (k = 0; k < 10 && out_valid_o !== 1'b1; k++) begin
      @(posedge ref_clk_i);
      #1;
    end
    chk(i_out_o, ei);
    chk(q_out_o, eq);
  endtask
  task automatic wait_off(input logic v, input int n);
    int k;
    for (k = 0; k < n && output_off_o !== v; k++) begin
      @(posedge ref_clk_i);
      #1;
    end
    chk({15'h0000, output_off_o}, {15'h0000, v});
  endtask
  task automatic t_reset;
    logic [7:0] e;
    for (int a = 8'h37; a <= 8'h42; a++) begin
      e = (a == 8'h3f || a == 8'h40) ? 8'h20 : (a == 8'h41) ? 8'h01 : (a == 8'h42) ? 8'h41 : 8'h00;
      rchk(8'(a), e);
    end
    wr(8'h3a, 8'hff);
    wr(8'h42, 8'h01);
    wr(8'h39, 8'hff);
    rchk(8'h3a, 8'h00);
    rchk(8'h42, 8'h41);
    rchk(8'h39, 8'h0f);
    $display("test reset done");
  endtask
  task automatic t_path;
    wr(8'h38, 8'h04);
    wr(8'h3b, 8'h05);
    wr(8'h3d, 8'h03);
    wr(8'h3f, 8'h10);
    smp(16'h010f, 16'h0200, 16'h0085, 16'h0213);
    wr(8'h3c, 8'h80);
    wr(8'h3e, 8'h01);
    smp(16'h010f, 16'h0200, 16'h8085, 16'h0313);
    wr(8'h3c, 8'h00);
    wr(8'h3e, 8'h00);
    wr(8'h37, 8'h80);
    wr(8'h38, 8'h1c);
    wr(8'h40, 8'h08);
    smp(16'h010f, 16'h0200, 16'h0085, 16'h007f);
    $display("test datapath done");
  endtask
  task automatic t_ramp;
    wr(8'h41, 8'h03);
    wr(8'h42, 8'h03);
    iq_gain_func_en_i <= 1'b1;
    wait_off(1'b0, 8);
    wr(8'h42, 8'h83);
    repeat (8) @(posedge ref_clk_i);
    #1;
    chk({15'h0000, output_off_o}, 16'h0000);
    wait_off(1'b1, 6);
    rchk(8'h42, 8'hc3);
    wr(8'h42, 8'h03);
    wait_off(1'b0, 6);
    repeat (16) @(posedge ref_clk_i);
    smp(16'h010f, 16'h0200, 16'h0085, 16'h007f);
    $display("test ramp done");
  endtask
  task automatic t_gate;
    @(posedge ref_clk_i);
    gate_step_en_i <= 1'b1;
    transmit_gate_i <= 1'b0;
    wait_off(1'b1, 16);
    repeat (150) @(posedge ref_clk_i);
    transmit_gate_i <= 1'b1;
    wait_off(1'b0, 6);
    @(posedge ref_clk_i);
    transmit_gate_i <= 1'b0;
    wait_off(1'b1, 16);
    @(posedge ref_clk_i);
    iq_gain_func_en_i <= 1'b0;
    transmit_gate_i <= 1'b1;
    repeat (12) @(posedge ref_clk_i);
    #1;
    chk({15'h0000, output_off_o}, 16'h0001);
    @(posedge ref_clk_i);
    iq_gain_func_en_i <= 1'b1;
    wait_off(1'b0, 6);
    $display("test gate done");
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    n_fail++;
    close_out;
  end
  initial begin
    n_fail = 0;
    cmp_count = 0;
    arst_n_i = 1'b0;
    {cfg_wr_i, cfg_rd_i, iq_gain_func_en_i, gate_step_en_i, send} = 5'h00;
    transmit_gate_i = 1'b1;
    {cfg_addr_i, cfg_wdata_i, i_word, q_word} = 48'h0;
    repeat (4) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    t_reset;
    t_path;
    t_ramp;
    t_gate;
    close_out;
  end
endmodule // testbench
